// File: dv/decenc_core_assertions.sv
// Concurrent checks on the error byte outputs of the encoder core
`timescale 1ns/1ns
`default_nettype none
module decenc_chk (
  input wire logic       aclk,            // Clock
  input wire logic       aresetn,         // Reset
  input wire logic       s_axi_awvalid,   // Write address
  input wire logic       s_axi_wvalid,    // Write data
  input wire logic       s_axi_arvalid,   // Read address
  input wire logic       diag_evt,        // Diag event
  input wire logic [2:0] diag_unit,       // Unit
  input wire logic [7:0] diag_code,       // Subcode
  input wire logic       dcc_evt,         // Ctrl event
  input wire logic       dcc_medium,      // Medium
  input wire logic [6:0] dcc_stat18,      // Status
  input wire logic [7:0] dcc_stat19,      // Errors
  input wire logic [7:0] dcc_retries,     // Retries
  input wire logic       mech_evt,        // Mech event
  input wire logic       sense_read_done, // Read done
  input wire logic       err_valid,       // Held
  input wire logic [1:0] err_form,        // Form
  input wire logic [3:0] sense_key,       // Key
  input wire logic [7:0] err_byte18,      // Byte 18
  input wire logic [7:0] err_byte19,      // Byte 19
  input wire logic [7:0] err_byte20,      // Byte 20
  input wire logic [7:0] err_byte21       // Byte 21
);
  // Any bus request that might release the held bytes
  wire logic bus_req = s_axi_awvalid | s_axi_wvalid | s_axi_arvalid;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  diag_map_a:
    assert property ($rose(err_valid) && $past(diag_evt) && $past(diag_unit) != 3'h7 |->
      err_form == 2'h2 && sense_key == 4'h4 && err_byte18 == 8'h41 + $past(diag_unit))
    else $error("diag byte 18 wrong");
  diag_sub_a:
    assert property ($rose(err_valid) && $past(diag_evt) |-> {err_byte20, err_byte21} == 16'h0
      && err_byte19 == ($past(diag_unit) == 3'h2 ? 8'h00 : $past(diag_code)))
    else $error("diag byte 19 wrong");
  diag_range_a:
    assert property (err_form == 2'h2 |-> err_byte18 >= 8'h40 && err_byte18 <= 8'h5f)
    else $error("diag range wrong");
  dcc_bytes_a:
    assert property ($rose(err_valid) && $past(dcc_evt) && !$past(diag_evt) |-> err_form == 2'h3
      && err_byte18[7:1] == ($past(dcc_stat18) | 7'h40) && err_byte19 == $past(dcc_stat19)
      && err_byte21 == $past(dcc_retries) && sense_key == ($past(dcc_medium) ? 4'h3 : 4'h1))
    else $error("ctrl bytes wrong");
  dcc_form_a:
    assert property (err_form == 2'h3 |-> err_byte18[7] && !err_byte18[0] && err_byte20 == 8'h00)
    else $error("ctrl form wrong");
  mech_form_a:
    assert property (err_form == 2'h1 |-> err_byte18 < 8'h40 && !err_byte19[0] && !err_byte20)
    else $error("mech form wrong");
  hold_a:
    assert property (err_valid && !sense_read_done && !bus_req && !$past(bus_req) |=>
      err_valid && $stable({err_byte18, err_byte19, err_byte21, err_form}))
    else $error("held bytes changed");
  release_a:
    assert property (err_valid && sense_read_done && !diag_evt && !dcc_evt && !mech_evt
      |=> !err_valid && sense_key == 4'h0)
    else $error("release missed");
  idle_a:
    assert property (!err_valid |-> err_form == 2'h0 && {err_byte18, err_byte19, err_byte21} == 0)
    else $error("idle bytes not clear");
endmodule : decenc_chk
bind decenc_core decenc_chk i_decenc_chk (.*);
`default_nettype wire

// File: dv/decenc_core_tb.sv
// Self-checking bench for the device error byte encoder core
`timescale 1ns/1ns
`default_nettype none
`include "decenc_map.svh"
module decenc_core_tb;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [3:0]       s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, read_delay = 4'h2;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dcc_medium = 1'b0;
  logic             mech_hard = 1'b0;
  logic [2:0]       evts = 3'h0, diag_unit = 3'h0;
  logic [7:0]       diag_code = 8'h0, dcc_stat19 = 8'h0, dcc_retries = 8'h0;
  logic [6:0]       dcc_stat18 = 7'h0, mech_stat19 = 7'h0;
  logic [5:0]       mech_stat18 = 6'h0;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic        err_valid, sense_read_done;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp, err_form;
  wire logic [3:0]  sense_key;
  wire logic [7:0]  err_byte18, err_byte19, err_byte20, err_byte21;
  wire logic [31:0] s_axi_rdata, sense_word;
  wire logic [31:0] bytes = {err_byte18, err_byte19, err_byte20, err_byte21};
  int               n_errors = 0;
  int               n_checks = 0;
  logic [11:0]      diag_tbl [28] = '{12'h011, 12'h012, 12'h021, 12'h022, 12'h031, 12'h032,
    12'h111, 12'h112, 12'h120, 12'h130, 12'h25a, 12'h330, 12'h350, 12'h351, 12'h352, 12'h353,
    12'h354, 12'h355, 12'h356, 12'h411, 12'h412, 12'h420, 12'h430, 12'h440, 12'h560, 12'h600,
    12'h67f, 12'h681};
  decenc_core i_decenc_core (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0),
    .diag_evt(evts[2]), .dcc_evt(evts[1]), .mech_evt(evts[0]), .mech_ext(8'h1b));
  decenc_initiator i_decenc_initiator (.*, .err_bytes(bytes));
  // Clock, 4 ns period
  always #2 aclk = ~aclk;
  // Verdict and end of run
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // A wait that ran out ends the run
  task automatic lim(input logic ok);
    if (!ok) begin
      chk("timeout", 1, 0);
      complete_run();
    end
  endtask : lim
  // Register write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !b; i++) begin
      #1;
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    lim(b);
    chk("bresp", 2'h0, r);
  endtask : wr
  // Register read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ar, v;
    logic [1:0] r;
    v = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !v; i++) begin
      #1;
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    lim(v);
    chk("rresp", 2'h0, r);
  endtask : rd
  // One-cycle event pulse, called at a rising edge
  task automatic fire(input logic [2:0] e);
    evts <= e;
    @(posedge aclk);
    evts <= 3'h0;
  endtask : fire
  // Bounded wait for the held flag
  task automatic wait_v(input logic v);
    for (int i = 0; i < 50; i++) begin
      #1;
      if (err_valid === v) break;
      @(posedge aclk);
    end
    lim(err_valid === v);
  endtask : wait_v
  // Register values after reset
  task automatic t_regs();
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      rd(k[3:0] * 4'h4, d);
      chk("reg_reset", k == 0, d);
    end
  endtask : t_regs
  // Diagnostic units 0 to 6 with the subcodes in diag_tbl
  task automatic t_diag();
    logic [2:0] u;
    for (int k = 0; k < 28; k++) begin
      u = diag_tbl[k][10:8];
      @(posedge aclk);
      diag_unit <= u;
      diag_code <= diag_tbl[k][7:0];
      fire(3'h4);
      wait_v(1'b1);
      chk("diag_b18", 8'h41 + u, err_byte18);
      chk("diag_b19", u == 3'h2 ? 8'h00 : diag_tbl[k][7:0], err_byte19);
      chk("diag_rest", {4'h4, 2'h2, 16'h0}, {sense_key, err_form, bytes[15:0]});
      wait_v(1'b0);
    end
  endtask : t_diag
  // Controller status, both keys, also read over the bus
  task automatic t_dcc();
    logic [31:0] d, e;
    read_delay <= 4'h8;
    for (int k = 0; k < 2; k++) begin
      e = k ? 32'haa5a0004 : 32'hd4a50003;
      @(posedge aclk);
      dcc_medium <= k[0];
      dcc_stat18 <= k ? 7'h55 : 7'h2a;
      dcc_stat19 <= e[23:16];
      dcc_retries <= e[7:0];
      fire(3'h2);
      wait_v(1'b1);
      chk("dcc_bytes", e, bytes);
      chk("dcc_key", {k ? 4'h3 : 4'h1, 2'h3}, {sense_key, err_form});
      rd(`DECENC_OFF_BYTES, d);
      chk("bytes_reg", e, d);
      wait_v(1'b0);
      chk("sense_word", e, sense_word);
    end
    read_delay <= 4'h2;
  endtask : t_dcc
  // Mechanism form with and without extended status
  task automatic t_mech();
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      mech_hard <= !k[0];
      mech_stat18 <= k ? 6'h15 : 6'h2a;
      mech_stat19 <= k ? 7'h40 : 7'h02;
      fire(3'h1);
      wait_v(1'b1);
      chk("mech_bytes", k ? 32'h15800000 : 32'h2a04001b, bytes);
      chk("mech_key", {k ? 4'h1 : 4'h4, 2'h1}, {sense_key, err_form});
      wait_v(1'b0);
    end
  endtask : t_mech
  // Later events refused while held, release by command
  task automatic t_hold();
    logic [31:0] d;
    read_delay <= 4'hf;
    @(posedge aclk);
    fire(3'h2);
    wait_v(1'b1);
    @(posedge aclk);
    fire(3'h1);
    @(posedge aclk);
    fire(3'h4);
    @(posedge aclk);
    #1;
    chk("held", 32'haa5a0004, bytes);
    rd(`DECENC_OFF_STAT, d);
    chk("lost", 1'b1, d[3]);
    wr(`DECENC_OFF_CMD, 32'h1);
    wait_v(1'b0);
    chk("cleared", 32'h0, bytes);
    wr(`DECENC_OFF_STAT, 32'h8);
    rd(`DECENC_OFF_STAT, d);
    chk("lost_clr", 1'b0, d[3]);
    read_delay <= 4'h2;
  endtask : t_hold
  // Simultaneous events: the diagnostic one wins
  task automatic t_prio();
    logic [31:0] d;
    @(posedge aclk);
    diag_unit <= 3'h6;
    diag_code <= 8'h81;
    fire(3'h7);
    wait_v(1'b1);
    chk("prio", {8'h47, 8'h81, 2'h2}, {err_byte18, err_byte19, err_form});
    wait_v(1'b0);
    @(posedge aclk);
    diag_unit <= 3'h7;
    fire(3'h4);
    wait_v(1'b1);
    chk("undef_b18", 8'h40, err_byte18);
    rd(`DECENC_OFF_STAT, d);
    chk("bad", 1'b1, d[4]);
  endtask : t_prio
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_diag();
    t_dcc();
    t_mech();
    t_hold();
    t_prio();
    complete_run();
  end
endmodule : decenc_core_tb
`default_nettype wire

// File: dv/decenc_initiator.sv
// Initiator model that reads the held sense bytes and then releases them
`timescale 1ns/1ns
`default_nettype none
module decenc_initiator (
  input  wire logic [3:0]  read_delay,      // Cycles before read, f never
  input  wire logic        aclk,            // Clock
  input  wire logic        aresetn,         // Reset
  input  wire logic        err_valid,       // Bytes held
  input  wire logic [31:0] err_bytes,       // Bytes 18 to 21
  output logic             sense_read_done, // Read finished
  output logic [31:0]      sense_word       // Bytes as read
);
  logic [3:0] wait_cnt;
  // Count the hold time, then read the bytes and pulse done once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt        <= 4'h0;
      sense_read_done <= 1'b0;
      sense_word      <= 32'h0;
    end else begin
      sense_read_done <= 1'b0;
      wait_cnt        <= (err_valid && !sense_read_done) ? wait_cnt + 4'h1 : 4'h0;
      if (err_valid && !sense_read_done && wait_cnt == read_delay && read_delay != 4'hf) begin
        sense_read_done <= 1'b1;
        sense_word      <= err_bytes;
      end
    end
  end
endmodule : decenc_initiator
`default_nettype wire

// File: hdl/decenc_core.sv
// Device error byte encoder with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "decenc_map.svh"
module decenc_core (
  input  wire logic                 aclk,          // Clock, 250 MHz
  input  wire logic                 aresetn,       // Synchronous reset, active low
  input  wire logic [`DECENC_AW-1:0] s_axi_awaddr, // Write address
  input  wire logic [2:0]           s_axi_awprot,  // Write protection, unused
  input  wire logic                 s_axi_awvalid, // Write address valid
  output logic                      s_axi_awready, // Write address ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Write byte strobes
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output logic                      s_axi_wready,  // Write data ready
  output logic [1:0]                s_axi_bresp,   // Write response
  output logic                      s_axi_bvalid,  // Write response valid
  input  wire logic                 s_axi_bready,  // Write response ready
  input  wire logic [`DECENC_AW-1:0] s_axi_araddr, // Read address
  input  wire logic [2:0]           s_axi_arprot,  // Read protection, unused
  input  wire logic                 s_axi_arvalid, // Read address valid
  output logic                      s_axi_arready, // Read address ready
  output logic [31:0]               s_axi_rdata,   // Read data
  output logic [1:0]                s_axi_rresp,   // Read response
  output logic                      s_axi_rvalid,  // Read data valid
  input  wire logic                 s_axi_rready,  // Read data ready
  input  wire logic                 diag_evt,      // Diagnostic failure pulse
  input  wire logic [2:0]           diag_unit,     // Failing unit
  input  wire logic [7:0]           diag_code,     // Failure subcode
  input  wire logic                 dcc_evt,       // Controller chip error pulse
  input  wire logic                 dcc_medium,    // Unrecovered medium error
  input  wire logic [6:0]           dcc_stat18,    // Controller status bits 7..1
  input  wire logic [7:0]           dcc_stat19,    // Controller error bits 7..0
  input  wire logic [7:0]           dcc_retries,   // Retries attempted
  input  wire logic                 mech_evt,      // Mechanism status pulse
  input  wire logic                 mech_hard,     // Mechanism fault is hard
  input  wire logic [5:0]           mech_stat18,   // Mechanism byte 18 bits 5..0
  input  wire logic [6:0]           mech_stat19,   // Mechanism byte 19 bits 7..1
  input  wire logic [7:0]           mech_ext,      // Extended mechanism status
  input  wire logic                 sense_read_done, // Initiator read the sense
  output logic                      err_valid,     // Error bytes held
  output logic [1:0]                err_form,      // Form of the held bytes
  output logic [3:0]                sense_key,     // Sense key to report
  output logic [7:0]                err_byte18,    // Device error byte 18
  output logic [7:0]                err_byte19,    // Device error byte 19
  output logic [7:0]                err_byte20,    // Device error byte 20
  output logic [7:0]                err_byte21     // Device error byte 21
);
  typedef struct packed {
    logic                  aw_have;
    logic [`DECENC_AW-1:0] aw_addr;
    logic                  w_have;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  cap_en;
    logic                  cor;
    logic                  valid;
    decenc_pkg::decenc_form_t form;
    logic [3:0]            key;
    logic [7:0]            b18;
    logic [7:0]            b19;
    logic [7:0]            b20;
    logic [7:0]            b21;
    logic [7:0]            cnt;
  } decenc_core_t;

  decenc_core_t r;
  decenc_core_t next_r;

  logic       aw_take;
  logic       w_take;
  logic       wr_go;
  logic       rd_go;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;
  logic       cmd_rel;
  logic       lost_clr;
  logic       bad_clr;
  logic       release_now;
  logic       free;
  logic       take_diag;
  logic       take_dcc;
  logic       take_mech;
  logic       lost_set;
  logic       bad_set;
  logic       lost;
  logic       bad;
  logic [7:0] diag_b18;
  logic [7:0] diag_b19;
  logic       diag_legal;

  // Handshake outputs follow the holding flags
  assign s_axi_awready = !r.aw_have && !r.bvalid;
  assign s_axi_wready  = !r.w_have && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

  // Bus events: a write runs once address and data are both held
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_go   = r.aw_have && r.w_have && !r.bvalid;
  assign rd_go   = s_axi_arvalid && s_axi_arready;

  // Write decode: control fields, clears and release command
  always_comb begin
    wr_resp  = `DECENC_RESP_OKAY;
    cmd_rel  = 1'b0;
    lost_clr = 1'b0;
    bad_clr  = 1'b0;
    case (r.aw_addr)
      `DECENC_OFF_CTRL: ;
      `DECENC_OFF_BYTES: ;
      `DECENC_OFF_STAT: begin
        lost_clr = wr_go && r.w_strb[0] && r.w_data[`DECENC_STAT_LOST];
        bad_clr  = wr_go && r.w_strb[0] && r.w_data[`DECENC_STAT_BAD];
      end
      `DECENC_OFF_CMD: begin
        cmd_rel = wr_go && r.w_strb[0] && r.w_data[`DECENC_CMD_REL];
      end
      default: wr_resp = `DECENC_RESP_DECERR;
    endcase
  end

  // Read mux: control, status with capture count, the four bytes
  always_comb begin
    rd_data = 32'h0;
    rd_resp = `DECENC_RESP_OKAY;
    case (s_axi_araddr)
      `DECENC_OFF_CTRL: begin
        rd_data[`DECENC_CTRL_EN]  = r.cap_en;
        rd_data[`DECENC_CTRL_COR] = r.cor;
      end
      `DECENC_OFF_STAT: begin
        rd_data[`DECENC_STAT_VALID]            = r.valid;
        rd_data[`DECENC_STAT_FORM +: 2]        = r.form;
        rd_data[`DECENC_STAT_LOST]             = lost;
        rd_data[`DECENC_STAT_BAD]              = bad;
        rd_data[`DECENC_STAT_CNT +: 8]         = r.cnt;
      end
      `DECENC_OFF_BYTES: rd_data = {r.b18, r.b19, r.b20, r.b21};
      `DECENC_OFF_CMD: ;
      default: rd_resp = `DECENC_RESP_DECERR;
    endcase
  end

  // Held bytes are released by the initiator, a command or a read
  assign release_now = sense_read_done || cmd_rel ||
                       (rd_go && r.cor && (s_axi_araddr == `DECENC_OFF_BYTES));
  assign free = !r.valid || release_now;

  // One source is taken per cycle: diagnostics first, then controller
  assign take_diag = diag_evt && r.cap_en && free;
  assign take_dcc  = dcc_evt && !diag_evt && r.cap_en && free;
  assign take_mech = mech_evt && !diag_evt && !dcc_evt && r.cap_en && free;

  // Any event refused while enabled is reported as lost
  assign lost_set = r.cap_en && ((diag_evt && !take_diag) ||
                                 (dcc_evt && !take_dcc) ||
                                 (mech_evt && !take_mech));
  assign bad_set  = take_diag && !diag_legal;

  // Unit and subcode mapping for the diagnostic form
  decenc_diag_check u_diag (
    .unit  (diag_unit),
    .code  (diag_code),
    .b18   (diag_b18),
    .b19   (diag_b19),
    .legal (diag_legal)
  );

  // Event lost flag, write one to clear
  decenc_sticky u_lost (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (lost_set),
    .clr     (lost_clr),
    .flag    (lost)
  );

  // Undefined unit or subcode flag, write one to clear
  decenc_sticky u_bad (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (bad_set),
    .clr     (bad_clr),
    .flag    (bad)
  );

  // Next state of bus slave and error byte store
  always_comb begin
    next_r = r;
    // Write address and data are caught in either order
    if (aw_take) begin
      next_r.aw_have = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_r.w_have = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    // Write executes, then the response waits for bready
    if (wr_go) begin
      next_r.aw_have = 1'b0;
      next_r.w_have  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = wr_resp;
      if ((r.aw_addr == `DECENC_OFF_CTRL) && r.w_strb[0]) begin
        next_r.cap_en = r.w_data[`DECENC_CTRL_EN];
        next_r.cor    = r.w_data[`DECENC_CTRL_COR];
      end
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
    // Read data are registered and held until rready
    if (rd_go) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_data;
      next_r.rresp  = rd_resp;
    end
    if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
    // Release clears the bytes; a new capture in the same cycle wins
    if (release_now) begin
      next_r.valid = 1'b0;
      next_r.form  = decenc_pkg::DECENC_FORM_NONE;
      next_r.key   = `DECENC_KEY_NONE;
      next_r.b18   = 8'h0;
      next_r.b19   = 8'h0;
      next_r.b20   = 8'h0;
      next_r.b21   = 8'h0;
    end
    // Diagnostic result form, bytes 20 and 21 zero
    if (take_diag) begin
      next_r.valid = 1'b1;
      next_r.form  = decenc_pkg::DECENC_FORM_DIAG;
      next_r.key   = `DECENC_KEY_HARD;
      next_r.b18   = diag_b18;
      next_r.b19   = diag_b19;
      next_r.b20   = 8'h0;
      next_r.b21   = 8'h0;
    end
    // Controller status form; bit 7 kept set to stay in range
    if (take_dcc) begin
      next_r.valid = 1'b1;
      next_r.form  = decenc_pkg::DECENC_FORM_DCC;
      next_r.key   = dcc_medium ? `DECENC_KEY_MEDIUM : `DECENC_KEY_RECOV;
      next_r.b18   = {1'b1, dcc_stat18[5:0], 1'b0};
      next_r.b18[7] = 1'b1 | dcc_stat18[6];
      next_r.b19   = dcc_stat19;
      next_r.b20   = 8'h0;
      next_r.b21   = dcc_retries;
    end
    // Mechanism status form, byte 21 only with extended status
    if (take_mech) begin
      next_r.valid = 1'b1;
      next_r.form  = decenc_pkg::DECENC_FORM_MECH;
      next_r.key   = mech_hard ? `DECENC_KEY_HARD : `DECENC_KEY_RECOV;
      next_r.b18   = {2'b00, mech_stat18};
      next_r.b19   = {mech_stat19, 1'b0};
      next_r.b20   = 8'h0;
      next_r.b21   = mech_stat19[`DECENC_MECH_EXT - 1] ? mech_ext : 8'h0;
    end
    // Count of captured faults, wraps
    if (take_diag || take_dcc || take_mech) next_r.cnt = r.cnt + 8'h1;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.cap_en <= `DECENC_CTRL_RST;
    end else begin
      r <= next_r;
    end
  end

  // Held bytes drive the sense data path
  assign err_valid  = r.valid;
  assign err_form   = r.form;
  assign sense_key  = r.key;
  assign err_byte18 = r.b18;
  assign err_byte19 = r.b19;
  assign err_byte20 = r.b20;
  assign err_byte21 = r.b21;
endmodule : decenc_core
`default_nettype wire

// File: hdl/decenc_diag_check.sv
// Maps a diagnostic failure unit and subcode onto bytes 18 and 19
`timescale 1ns/1ns
`default_nettype none
`include "decenc_map.svh"
module decenc_diag_check (
  input  wire logic [2:0] unit,   // Failing unit
  input  wire logic [7:0] code,   // Raw subcode
  output logic      [7:0] b18,    // Byte 18 value
  output logic      [7:0] b19,    // Byte 19 value
  output logic            legal   // Subcode is a defined one
);
  // Unit selects byte 18, subcode is checked against its list; the checksum unit accepts any subcode and sends 00
  always_comb begin
    b19   = code;
    legal = 1'b1;
    case (decenc_pkg::decenc_unit_t'(unit))
      decenc_pkg::DECENC_UNIT_CPU: begin
        b18   = `DECENC_B18_CPU;
        legal = code inside {`DECENC_SUB_DREG, `DECENC_SUB_DFADE, `DECENC_SUB_AREG,
                             `DECENC_SUB_AFADE, `DECENC_SUB_COND, `DECENC_SUB_AMODE};
      end
      decenc_pkg::DECENC_UNIT_WMEM: begin
        b18   = `DECENC_B18_WMEM;
        legal = code inside {`DECENC_SUB_WALK0, `DECENC_SUB_WALK1,
                             `DECENC_SUB_MARCH, `DECENC_SUB_COMPL};
      end
      decenc_pkg::DECENC_UNIT_CSUM: begin
        b18 = `DECENC_B18_CSUM;
        b19 = `DECENC_SUB_ZERO;
      end
      decenc_pkg::DECENC_UNIT_BIC: begin
        b18   = `DECENC_B18_BIC;
        legal = code inside {`DECENC_SUB_BRAM, [`DECENC_SUB_BREG:`DECENC_SUB_BPATH]};
      end
      decenc_pkg::DECENC_UNIT_BUF: begin
        b18   = `DECENC_B18_BUF;
        legal = code inside {`DECENC_SUB_WALK0, `DECENC_SUB_WALK1, `DECENC_SUB_MARCH,
                             `DECENC_SUB_COMPL, `DECENC_SUB_ADDR};
      end
      decenc_pkg::DECENC_UNIT_DCC: begin
        b18   = `DECENC_B18_DCC;
        legal = (code == `DECENC_SUB_DCCREG);
      end
      decenc_pkg::DECENC_UNIT_WR: begin
        b18   = `DECENC_B18_WR;
        legal = (code <= `DECENC_SUB_ASCMAX) || (code == `DECENC_SUB_BUFCMP);
      end
      default: begin
        b18   = `DECENC_DIAG_LO;
        legal = 1'b0;
      end
    endcase
  end
endmodule : decenc_diag_check
`default_nettype wire

// File: hdl/decenc_map.svh
// Offsets, fields, codes and reset values of the device error byte encoder
`ifndef DECENC_MAP_SVH
`define DECENC_MAP_SVH
`define DECENC_AW          4
`define DECENC_OFF_CTRL    4'h0
`define DECENC_OFF_STAT    4'h4
`define DECENC_OFF_BYTES   4'h8
`define DECENC_OFF_CMD     4'hc
`define DECENC_CTRL_EN     0
`define DECENC_CTRL_COR    1
`define DECENC_CTRL_RST    1'b1
`define DECENC_STAT_VALID  0
`define DECENC_STAT_FORM   1
`define DECENC_STAT_LOST   3
`define DECENC_STAT_BAD    4
`define DECENC_STAT_CNT    8
`define DECENC_CMD_REL     0
`define DECENC_RESP_OKAY   2'h0
`define DECENC_RESP_DECERR 2'h3
`define DECENC_KEY_NONE    4'h0
`define DECENC_KEY_RECOV   4'h1
`define DECENC_KEY_MEDIUM  4'h3
`define DECENC_KEY_HARD    4'h4
`define DECENC_DIAG_LO     8'h40
`define DECENC_B18_CPU     8'h41
`define DECENC_B18_WMEM    8'h42
`define DECENC_B18_CSUM    8'h43
`define DECENC_B18_BIC     8'h44
`define DECENC_B18_BUF     8'h45
`define DECENC_B18_DCC     8'h46
`define DECENC_B18_WR      8'h47
`define DECENC_SUB_ZERO    8'h00
`define DECENC_SUB_DREG    8'h11
`define DECENC_SUB_DFADE   8'h12
`define DECENC_SUB_AREG    8'h21
`define DECENC_SUB_AFADE   8'h22
`define DECENC_SUB_COND    8'h31
`define DECENC_SUB_AMODE   8'h32
`define DECENC_SUB_WALK0   8'h11
`define DECENC_SUB_WALK1   8'h12
`define DECENC_SUB_MARCH   8'h20
`define DECENC_SUB_COMPL   8'h30
`define DECENC_SUB_ADDR    8'h40
`define DECENC_SUB_BRAM    8'h30
`define DECENC_SUB_BREG    8'h50
`define DECENC_SUB_BCMD    8'h51
`define DECENC_SUB_BMSGO   8'h52
`define DECENC_SUB_BMSGI   8'h53
`define DECENC_SUB_BST0    8'h54
`define DECENC_SUB_BST1    8'h55
`define DECENC_SUB_BPATH   8'h56
`define DECENC_SUB_DCCREG  8'h60
`define DECENC_SUB_ASCMAX  8'h7f
`define DECENC_SUB_BUFCMP  8'h81
`define DECENC_MECH_EXT    2
`endif

// File: hdl/decenc_pkg.sv
// Types shared by the device error byte encoder
package decenc_pkg;
  typedef enum logic [2:0] {
    DECENC_UNIT_CPU  = 3'h0,
    DECENC_UNIT_WMEM = 3'h1,
    DECENC_UNIT_CSUM = 3'h2,
    DECENC_UNIT_BIC  = 3'h3,
    DECENC_UNIT_BUF  = 3'h4,
    DECENC_UNIT_DCC  = 3'h5,
    DECENC_UNIT_WR   = 3'h6
  } decenc_unit_t;
  typedef enum logic [1:0] {
    DECENC_FORM_NONE = 2'h0,
    DECENC_FORM_MECH = 2'h1,
    DECENC_FORM_DIAG = 2'h2,
    DECENC_FORM_DCC  = 2'h3
  } decenc_form_t;
  typedef struct packed {
    logic flag;
  } decenc_sticky_t;
endpackage : decenc_pkg

// File: hdl/decenc_sticky.sv
// Sticky flag where a set beats a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module decenc_sticky (
  input  wire logic aclk,     // Clock
  input  wire logic aresetn,  // Synchronous reset, active low
  input  wire logic set,      // Event sets the flag
  input  wire logic clr,      // Software clear
  output logic      flag      // Flag state
);
  decenc_pkg::decenc_sticky_t r;
  decenc_pkg::decenc_sticky_t next_r;

  // Clear first so a simultaneous set survives
  always_comb begin
    next_r = r;
    if (clr) next_r.flag = 1'b0;
    if (set) next_r.flag = 1'b1;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) r <= '0;
    else r <= next_r;
  end

  assign flag = r.flag;
endmodule : decenc_sticky
`default_nettype wire
